// >>> src/smst_top.v
/*
 Reference-drift monitor and comparator self-test with an AXI4-Lite slave.
 Assumes comparator and reference-compare inputs synchronous to aclk; the
 analog front end applies the test stimulus selected by the force outputs.
*/
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "smst_defs.vh"
`default_nettype none

module smst_top #(
   parameter NBUCK = 3,
   parameter NLIN = 1,
   parameter SAFETY_VARIANT = 1,
   parameter SETTLE_CYC = `SMST_SETTLE_CYC,
   parameter BLANK_CYC = `SMST_BLANK_CYC
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire powerup_request,
   input wire system_on,
   input wire reference_mismatch,
   input wire [NBUCK+NLIN-1:0] ov_comparator,
   input wire [NBUCK+NLIN-1:0] uv_comparator,
   input wire power_good_readback,
   output reg [NBUCK+NLIN-1:0] ov_force,
   output reg [NBUCK+NLIN-1:0] uv_force,
   output reg power_good_output,
   output reg fault_blank,
   output reg regulator_enable,
   output reg reference_fault_irq
);
   localparam N = NBUCK + NLIN;
   localparam S_IDLE = 6'b000001;
   localparam S_FORCE = 6'b000010;
   localparam S_RELEASE = 6'b000100;
   localparam S_POWER_GOOD_OUTPUT = 6'b001000;
   localparam S_NEXT = 6'b010000;
   localparam S_DONE = 6'b100000;

   reg [5:0] state_r;
   reg [31:0] cnt_r;
   reg [31:0] blank_r;
   reg [7:0] idx_r;
   reg uv_phase_r;
   reg seen_r;
   reg ondemand_r;
   reg run_r;
   reg bypass_r;
   reg secure_en_r;
   reg secure_arm_r;
   reg irq_flag_r;
   reg irq_mask_r;
   reg pwrup_done_r;
   reg blocked_r;
   reg shutdown_r;
   reg pg_fail_r;
   reg [N-1:0] ov_res_r;
   reg [N-1:0] uv_res_r;
   reg [N-1:0] ov_new_r;
   reg [N-1:0] uv_new_r;
   reg [7:0] awaddr_r;
   reg [31:0] wdata_r;
   reg aw_have_r;
   reg w_have_r;

   wire ref_fault = reference_mismatch;
   wire busy = (state_r != S_IDLE);
   wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   wire wr_ok = !secure_en_r || secure_arm_r;
   wire [N-1:0] cur_sel = {{(N-1){1'b0}}, 1'b1} << idx_r;
   wire cmp_bit = uv_phase_r ? |(uv_comparator & cur_sel) : |(ov_comparator & cur_sel);
   wire run_write = wr_go && (awaddr_r == `SMST_ADDR_CTRL) && wdata_r[`SMST_CTRL_RUN];
   wire start_demand = run_write && wr_ok && !busy && !run_r;
   wire start_pwrup = powerup_request && !pwrup_done_r && !busy;

   function [31:0] pad;
      input [N-1:0] v;
      begin
         pad = 32'h00000000;
         pad[N-1:0] = v;
      end
   endfunction

   // Only the aligned words up to the secure register exist; all else errors
   function [1:0] bus_resp;
      input [7:0] a;
      begin
         if (a > `SMST_ADDR_SECURE || a[1:0] != 2'b00)
            bus_resp = 2'b10;
         else
            bus_resp = 2'b00;
      end
   endfunction

   // Words assembled by field position so the map is kept in one header
   reg [31:0] ctrl_w;
   reg [31:0] status_w;
   always @* begin
      ctrl_w = 32'h00000000;
      ctrl_w[`SMST_CTRL_RUN] = run_r;
      ctrl_w[`SMST_CTRL_BYPASS] = bypass_r;
      ctrl_w[`SMST_CTRL_SECURE_EN] = secure_en_r;
      status_w = 32'h00000000;
      status_w[`SMST_ST_REF_FAULT] = ref_fault;
      status_w[`SMST_ST_BUSY] = busy;
      status_w[`SMST_ST_PWRUP_DONE] = pwrup_done_r;
      status_w[`SMST_ST_BLOCKED] = blocked_r;
      status_w[`SMST_ST_SHUTDOWN] = shutdown_r;
      status_w[`SMST_ST_POWER_GOOD_OUTPUT_FAIL] = pg_fail_r;
   end

   // Write channel: address and data accepted in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= bus_resp(awaddr_r);
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= bus_resp(s_axi_araddr);
            case (s_axi_araddr)
               `SMST_ADDR_CTRL: s_axi_rdata <= ctrl_w;
               `SMST_ADDR_STATUS: s_axi_rdata <= status_w;
               `SMST_ADDR_IRQ: s_axi_rdata <= {31'h0, irq_flag_r};
               `SMST_ADDR_MASK: s_axi_rdata <= {31'h0, irq_mask_r};
               `SMST_ADDR_BUCK_OV: s_axi_rdata <= pad(ov_res_r & {{NLIN{1'b0}}, {NBUCK{1'b1}}});
               `SMST_ADDR_LIN_OV: s_axi_rdata <= pad(ov_res_r >> NBUCK);
               `SMST_ADDR_BUCK_UV: s_axi_rdata <= pad(uv_res_r & {{NLIN{1'b0}}, {NBUCK{1'b1}}});
               `SMST_ADDR_LIN_UV: s_axi_rdata <= pad(uv_res_r >> NBUCK);
               `SMST_ADDR_SECURE: s_axi_rdata <= {31'h0, secure_arm_r};
               default: s_axi_rdata <= 32'h00000000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Register writes, secure arming and reference fault handling
   always @(posedge aclk) begin
      if (!aresetn) begin
         bypass_r <= 1'b0;
         secure_en_r <= 1'b0;
         secure_arm_r <= 1'b0;
         irq_flag_r <= 1'b0;
         irq_mask_r <= 1'b0;
         shutdown_r <= 1'b0;
         reference_fault_irq <= 1'b0;
      end else begin
         // A key arms exactly one following write; any other write disarms
         if (wr_go)
            secure_arm_r <= (awaddr_r == `SMST_ADDR_SECURE) && (wdata_r == `SMST_SECURE_KEY);
         if (wr_go && awaddr_r == `SMST_ADDR_CTRL) begin
            bypass_r <= wdata_r[`SMST_CTRL_BYPASS];
            // Lifting protection needs an armed write like any guarded field
            if (wr_ok)
               secure_en_r <= wdata_r[`SMST_CTRL_SECURE_EN];
         end
         if (wr_go && awaddr_r == `SMST_ADDR_MASK)
            irq_mask_r <= wdata_r[0];
         if (wr_go && awaddr_r == `SMST_ADDR_IRQ && wdata_r[0])
            irq_flag_r <= 1'b0;
         // Set wins over a clear in the same cycle
         if (ref_fault && !irq_mask_r)
            irq_flag_r <= 1'b1;
         if (ref_fault && system_on && !bypass_r)
            shutdown_r <= 1'b1;
         reference_fault_irq <= irq_flag_r;
      end
   end

   // Self-test sequencer: each comparator forced, then released, must toggle
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= S_IDLE;
         cnt_r <= 32'h00000000;
         blank_r <= 32'h00000000;
         idx_r <= 8'h00;
         uv_phase_r <= 1'b0;
         seen_r <= 1'b0;
         ondemand_r <= 1'b0;
         run_r <= 1'b0;
         pwrup_done_r <= 1'b0;
         blocked_r <= 1'b0;
         pg_fail_r <= 1'b0;
         ov_res_r <= {N{1'b0}};
         uv_res_r <= {N{1'b0}};
         ov_new_r <= {N{1'b0}};
         uv_new_r <= {N{1'b0}};
         ov_force <= {N{1'b0}};
         uv_force <= {N{1'b0}};
         power_good_output <= 1'b0;
         fault_blank <= 1'b0;
         regulator_enable <= 1'b0;
      end else begin
         // Secure mode: results clear only after an armed write
         if (wr_go && wr_ok && !busy && (awaddr_r >= `SMST_ADDR_BUCK_OV) &&
               (awaddr_r <= `SMST_ADDR_LIN_UV)) begin
            ov_res_r <= {N{1'b0}};
            uv_res_r <= {N{1'b0}};
         end
         regulator_enable <= pwrup_done_r && !blocked_r && !shutdown_r;
         if (blank_r != 32'h00000000)
            blank_r <= blank_r - 32'h00000001;
         fault_blank <= ondemand_r && busy && (blank_r != 32'h00000000);
         case (state_r)
            S_IDLE: begin
               if (start_pwrup || start_demand) begin
                  run_r <= 1'b1;
                  ondemand_r <= start_demand;
                  blank_r <= BLANK_CYC;
                  idx_r <= 8'h00;
                  uv_phase_r <= 1'b0;
                  ov_new_r <= {N{1'b0}};
                  uv_new_r <= {N{1'b0}};
                  cnt_r <= 32'h00000000;
                  seen_r <= 1'b0;
                  state_r <= S_FORCE;
               end
            end
            S_FORCE: begin
               ov_force <= uv_phase_r ? {N{1'b0}} : cur_sel;
               uv_force <= uv_phase_r ? cur_sel : {N{1'b0}};
               cnt_r <= cnt_r + 32'h00000001;
               if (cmp_bit && cnt_r > 32'h00000001)
                  seen_r <= 1'b1;
               if (cnt_r == SETTLE_CYC) begin
                  cnt_r <= 32'h00000000;
                  state_r <= S_RELEASE;
               end
            end
            S_RELEASE: begin
               ov_force <= {N{1'b0}};
               uv_force <= {N{1'b0}};
               cnt_r <= cnt_r + 32'h00000001;
               if (cnt_r == SETTLE_CYC) begin
                  // A toggle means high while forced and low once released
                  if (!(seen_r && !cmp_bit)) begin
                     if (uv_phase_r)
                        uv_new_r <= uv_new_r | cur_sel;
                     else
                        ov_new_r <= ov_new_r | cur_sel;
                  end
                  cnt_r <= 32'h00000000;
                  state_r <= S_NEXT;
               end
            end
            S_NEXT: begin
               seen_r <= 1'b0;
               if (idx_r == N - 1) begin
                  idx_r <= 8'h00;
                  if (uv_phase_r)
                     state_r <= S_POWER_GOOD_OUTPUT;
                  else begin
                     uv_phase_r <= 1'b1;
                     state_r <= S_FORCE;
                  end
               end else begin
                  idx_r <= idx_r + 8'h01;
                  state_r <= S_FORCE;
               end
            end
            S_POWER_GOOD_OUTPUT: begin
               // Pulse the power-good pin and watch it read back
               cnt_r <= cnt_r + 32'h00000001;
               power_good_output <= (cnt_r < SETTLE_CYC);
               if (cnt_r == 32'h00000002)
                  seen_r <= power_good_readback;
               if (cnt_r == 2 * SETTLE_CYC) begin
                  pg_fail_r <= !(seen_r && !power_good_readback);
                  cnt_r <= 32'h00000000;
                  state_r <= S_DONE;
               end
            end
            S_DONE: begin
               ov_res_r <= ov_new_r;
               uv_res_r <= uv_new_r;
               run_r <= 1'b0;
               if (!ondemand_r) begin
                  pwrup_done_r <= 1'b1;
                  if (ref_fault && (SAFETY_VARIANT != 0))
                     blocked_r <= 1'b1;
                  else if (ref_fault && !bypass_r)
                     blocked_r <= 1'b1;
               end
               ondemand_r <= 1'b0;
               state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule

`default_nettype wire

// >>> src/smst_defs.vh
/*
 Constants for the safety monitor and comparator self-test block: register
 offsets, field positions, reset values and timing counts.
 Assumes a 125 MHz clock and 32-bit AXI4-Lite access, one word per register.
*/
// Function
// - Reference mismatch blocks regulator power-up
// - Safety variant: power-up mismatch fails, ignores bypass
// - System on, bypass 0: shut regulators down
// - System on, bypass 1: interrupt only
// - Reference fault flag set unless masked
// - Status bit follows live reference condition
// - Test covers all monitors and power-good
// - Exercise each overvoltage comparator individually
// - Exercise each undervoltage comparator individually
// - Non-toggling comparator sets a warning bit
// - Four result registers, one bit per regulator
// - Each run overwrites all result registers
// - Secure mode: ordinary writes cannot clear results
// - Power-up continues after test regardless
// - Run request starts test, self-clears
// - Blank fault monitoring at most 200 us
// - On-demand failures set per-regulator flags
`ifndef SMST_DEFS_VH
`define SMST_DEFS_VH

`define SMST_ADDR_CTRL 8'h00
`define SMST_ADDR_STATUS 8'h04
`define SMST_ADDR_IRQ 8'h08
`define SMST_ADDR_MASK 8'h0C
`define SMST_ADDR_BUCK_OV 8'h10
`define SMST_ADDR_LIN_OV 8'h14
`define SMST_ADDR_BUCK_UV 8'h18
`define SMST_ADDR_LIN_UV 8'h1C
`define SMST_ADDR_SECURE 8'h20

// Control register fields
`define SMST_CTRL_RUN 0
`define SMST_CTRL_BYPASS 1
`define SMST_CTRL_SECURE_EN 2
// Status register fields
`define SMST_ST_REF_FAULT 0
`define SMST_ST_BUSY 1
`define SMST_ST_PWRUP_DONE 2
`define SMST_ST_BLOCKED 3
`define SMST_ST_SHUTDOWN 4
`define SMST_ST_POWER_GOOD_OUTPUT_FAIL 5

// Secure write: writing this key to the secure register arms one write
`define SMST_SECURE_KEY 32'h0000005A
`define SMST_RST_CTRL 32'h00000000

// Blanking bound and per-comparator settle time
`define SMST_BLANK_US 200
`define SMST_CLK_MHZ 125
`define SMST_BLANK_CYC (`SMST_BLANK_US * `SMST_CLK_MHZ)
`define SMST_SETTLE_CYC 16

`endif

// >>> tb/smst_afe_model.sv
/*
 Analog front end model: comparators and power-good readback answer the
 force and power-good outputs one cycle late; a stuck input keeps a comparator from toggling.
 Assumes one clock, aclk, shared with the design.
*/
`timescale 1ns/1ps
`default_nettype none
module smst_afe_model #(parameter N = 4) (
   input wire logic aclk,
   input wire logic [N-1:0] ov_force,
   input wire logic [N-1:0] uv_force,
   input wire logic pg_drive,
   input wire logic [N-1:0] ov_stuck,
   input wire logic [N-1:0] uv_stuck,
   input wire logic pg_stuck,
   output logic [N-1:0] ov_cmp,
   output logic [N-1:0] uv_cmp,
   output logic pg_readback
);
   initial begin
      ov_cmp = 0;
      uv_cmp = 0;
      pg_readback = 0;
   end
   // Supplies are healthy outside tests, so an unforced comparator reads low
   always @(posedge aclk) begin
      ov_cmp <= ov_force & ~ov_stuck;
      uv_cmp <= uv_force & ~uv_stuck;
      pg_readback <= pg_drive & ~pg_stuck;
   end
endmodule
`default_nettype wire

// >>> tb/smst_props.sv
/*
 Checker for the self-test and reference monitor at the top module's ports.
 Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module smst_props #(parameter NBUCK = 3, parameter NLIN = 1, parameter SETTLE_CYC = 16,
   parameter BLANK_CYC = 25000) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic reference_mismatch,
   input wire logic [NBUCK+NLIN-1:0] ov_force,
   input wire logic [NBUCK+NLIN-1:0] uv_force,
   input wire logic fault_blank,
   input wire logic regulator_enable,
   input wire logic reference_fault_irq
);
   wire [2*(NBUCK+NLIN)-1:0] f = {ov_force, uv_force};
   reg [2*(NBUCK+NLIN)-1:0] f_q;
   reg [15:0] hold_n;
   reg [31:0] blank_n;
   always @(posedge aclk) begin
      if (!aresetn) begin
         f_q <= 0;
         hold_n <= 0;
         blank_n <= 0;
      end else begin
         f_q <= f;
         hold_n <= (f == f_q) ? hold_n + 16'h1 : 16'h1;
         blank_n <= fault_blank ? blank_n + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_force_ends;
      f_q != 0 && f != f_q;
   endsequence
   sequence s_forced;
      ##[0:3] (ov_force != 0);
   endsequence
   AST_BLANK_MAX: assert property (blank_n <= BLANK_CYC) else $error("blank too long");
   AST_BLANK_START: assert property ($rose(fault_blank) |-> s_forced)
      else $error("blank without test");
   AST_FORCE_ONEHOT: assert property ($onehot0(f)) else $error("two comparators forced");
   AST_FORCE_HOLD: assert property (s_force_ends |-> hold_n == SETTLE_CYC + 1)
      else $error("force length wrong");
   AST_PWRUP_BLOCK: assert property ($rose(regulator_enable) |-> !$past(reference_mismatch))
      else $error("power-up despite mismatch");
   AST_IRQ_CAUSE: assert property ($rose(reference_fault_irq) |-> $past(reference_mismatch)
      || $past(reference_mismatch, 2) || $past(reference_mismatch, 3)) else $error("irq no cause");
   AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready held");
   AST_BVALID_AFTER: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready, 2))
      else $error("bvalid timing");
   AST_RVALID_AFTER: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
      else $error("rvalid timing");
endmodule
bind smst_top smst_props #(.NBUCK(NBUCK), .NLIN(NLIN), .SETTLE_CYC(SETTLE_CYC),
   .BLANK_CYC(BLANK_CYC)) u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .reference_mismatch(reference_mismatch), .ov_force(ov_force),
   .uv_force(uv_force), .fault_blank(fault_blank), .regulator_enable(regulator_enable),
   .reference_fault_irq(reference_fault_irq));
`default_nettype wire

// >>> tb/smst_top_bench.sv
/*
 Self-checking bench: AXI4-Lite master tasks, front end model, result model.
 Assumes short settle and blank counts set through the design's parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module smst_top_bench;
   reg aclk = 0, aresetn = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
   reg [7:0] awa = 0, ara = 0;
   reg [31:0] wd = 0, rd;
   reg pwr = 0, son = 0, mis = 0, pgs = 0, exp_pg;
   reg [3:0] ovs = 0, uvs = 0;
   reg [1:0] rs;
   wire awr, wr, bv, arr, rv, pgo, blank, ren, irq, pgrb;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   wire [3:0] ovf, uvf, ovc, uvc;
   integer n_errors = 0, total_checks = 0, cyc = 0, i;
   integer exp_res[0:3];
   always #4 aclk = ~aclk;
   smst_top #(.SAFETY_VARIANT(1), .SETTLE_CYC(4), .BLANK_CYC(200)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .powerup_request(pwr),
      .system_on(son), .reference_mismatch(mis), .ov_comparator(ovc), .uv_comparator(uvc),
      .power_good_readback(pgrb), .ov_force(ovf), .uv_force(uvf), .power_good_output(pgo),
      .fault_blank(blank), .regulator_enable(ren), .reference_fault_irq(irq));
   smst_afe_model #(.N(4)) u_afe (.aclk(aclk), .ov_force(ovf), .uv_force(uvf), .pg_drive(pgo),
      .ov_stuck(ovs), .uv_stuck(uvs), .pg_stuck(pgs), .ov_cmp(ovc), .uv_cmp(uvc),
      .pg_readback(pgrb));
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         end_sim;
      end
   end
   task chk(input [8*10:1] nm, input [31:0] s, input [31:0] e);
      begin
         total_checks = total_checks + 1;
         if (s !== e) begin
            n_errors = n_errors + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   task axw(input [7:0] a, input [31:0] d);
      reg ad, dd;
      begin
         @(posedge aclk);
         awa <= a; wd <= d; awv <= 1; wv <= 1; brd <= 1; ad = 0; dd = 0;
         while (!(ad && dd)) begin
            @(posedge aclk);
            if (awr === 1) begin ad = 1; awv <= 0; end
            if (wr === 1) begin dd = 1; wv <= 0; end
         end
         while (bv !== 1) @(posedge aclk);
         brd <= 0; rs = br;
      end
   endtask
   task axr(input [7:0] a);
      begin
         @(posedge aclk);
         ara <= a; arv <= 1; rrd <= 1;
         @(posedge aclk);
         while (arr !== 1) @(posedge aclk);
         arv <= 0;
         while (rv !== 1) @(posedge aclk);
         rrd <= 0; rd = rdat; rs = rr;
      end
   endtask
   // Model of the result registers: a stuck comparator is a failing bit
   task setf;
      begin
         @(posedge aclk);
         rd = $urandom | 32'h1;
         ovs <= rd[3:0]; uvs <= rd[7:4]; pgs <= rd[8]; exp_pg = rd[8];
         exp_res[0] = rd[2:0]; exp_res[1] = rd[3]; exp_res[2] = rd[6:4]; exp_res[3] = rd[7];
      end
   endtask
   task resc;
      for (i = 0; i < 4; i = i + 1) begin
         axr(8'h10 + 4 * i);
         chk("result", rd, exp_res[i]);
      end
   endtask
   task waitrun;
      begin
         i = 0;
         do begin axr(8'h00); i = i + 1; end while (rd[0] !== 0 && i < 200);
         chk("run clear", rd[0], 0);
      end
   endtask
   initial begin
      i = $urandom(92222);
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      for (i = 0; i < 10; i = i + 1) begin
         axr(4 * i);
         chk("rst data", rd, 0);
         chk("rst resp", rs, (i == 9) ? 2 : 0);
      end
      axw(8'h24, 0);
      chk("bad wr", rs, 2);
      $display("test reset values done");
      setf;
      pwr <= 1;
      i = 0;
      while (ren !== 1 && i < 1000) begin @(posedge aclk); i = i + 1; end
      chk("reg enable", ren, 1);
      resc;
      axr(8'h04);
      chk("pwrup done", rd[2], 1);
      $display("test power-up self-test done");
      setf;
      axw(8'h00, 1);
      axr(8'h00);
      chk("run held", rd[0], 1);
      chk("blanking", blank, 1);
      axw(8'h00, 1);
      waitrun;
      resc;
      axr(8'h04);
      chk("power_good_output test", rd[5], exp_pg);
      repeat (20) @(posedge aclk);
      chk("no rerun", blank, 0);
      $display("test on-demand run done");
      axw(8'h0C, 0);
      chk("wr resp", rs, 0);
      axw(8'h00, 2);
      son <= 1; mis <= 1;
      repeat (6) @(posedge aclk);
      chk("keep regs", ren, 1);
      chk("irq", irq, 1);
      axr(8'h04);
      chk("live stat", rd[0], 1);
      mis <= 0;
      axr(8'h04);
      chk("live stat", rd[0], 0);
      axw(8'h08, 1);
      axr(8'h08);
      chk("irq clear", rd[0], 0);
      axw(8'h0C, 1);
      mis <= 1;
      repeat (6) @(posedge aclk);
      axr(8'h08);
      chk("irq masked", rd[0], 0);
      axw(8'h00, 0);
      repeat (6) @(posedge aclk);
      chk("shutdown", ren, 0);
      axr(8'h04);
      chk("shut stat", rd[4], 1);
      mis <= 0; son <= 0;
      $display("test reference drift done");
      axw(8'h00, 4);
      axw(8'h10, 0);
      resc;
      axw(8'h00, 5);
      repeat (3) @(posedge aclk);
      chk("secure run", blank, 0);
      axw(8'h00, 0);
      axr(8'h00);
      chk("secure on", rd[2], 1);
      axw(8'h20, 32'h0000005A);
      axw(8'h10, 0);
      for (i = 0; i < 4; i = i + 1) exp_res[i] = 0;
      resc;
      setf;
      axw(8'h20, 32'h0000005A);
      axw(8'h00, 5);
      waitrun;
      resc;
      $display("test secure writes done");
      aresetn <= 0; pwr <= 0; mis <= 1;
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      pwr <= 1;
      i = 0;
      do begin axr(8'h04); i = i + 1; end while (rd[2] !== 1 && i < 200);
      chk("blocked", rd[3], 1);
      chk("no power", ren, 0);
      chk("irq boot", irq, 1);
      $display("test blocked power-up done");
      end_sim;
   end
endmodule
`default_nettype wire
